// ### hw/ecp_defines.vh
`ifndef ECP_DEFINES_VH
`define ECP_DEFINES_VH

// register indices, byte address is four times the index
`define IDX_DATA      11'h000
`define IDX_DCR       11'h002
`define IDX_FIFO      11'h400
`define IDX_CFG_B     11'h401
`define IDX_EXT       11'h402
`define IDX_SELECT    11'h403

// operating modes in extended control bits 7:5
`define MODE_SPP      3'h0
`define MODE_PS2      3'h1
`define MODE_PPFIFO   3'h2
`define MODE_ECP      3'h3
`define MODE_EPP      3'h4
`define MODE_RSVD     3'h5
`define MODE_TEST     3'h6
`define MODE_CFG      3'h7

// extended control field positions
`define EXT_MODE_HI   7
`define EXT_MODE_LO   5
`define EXT_FAULT_DIS 4
`define EXT_DMA_EN    3
`define EXT_SVC_MASK  2
`define EXT_FULL      1
`define EXT_EMPTY     0

// dcr fields and reset values
`define DCR_DIR       5
`define DCR_RESET     6'h00
`define CTL_INVERT    4'hb
`define CFG_A_VALUE   8'h10
`define SELECT_RESET  7'h00

// fifo geometry and service thresholds
`define FIFO_DEPTH    5'h10
`define FIFO_AW       4
`define TX_FREE_THR   5'h08
`define RX_FILL_THR   5'h08

`endif

// ### hw/ecp_byte_fifo.v
`timescale 1ns/1ps
`include "ecp_defines.vh"

module ecp_byte_fifo (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       clear,
  input  wire       push,
  input  wire [8:0] wdata,
  input  wire       pop,
  output wire [8:0] rdata,
  output reg  [4:0] count,
  output wire       full,
  output wire       empty
);

  reg [8:0]           mem [0:15];
  reg [`FIFO_AW-1:0]  wr_ptr;
  reg [`FIFO_AW-1:0]  rd_ptr;
  reg [8:0]           last_reg;
  wire                push_ok;
  wire                pop_ok;

  assign full    = (count == `FIFO_DEPTH);
  assign empty   = (count == 5'h00);
  assign push_ok = push & ~full;
  assign pop_ok  = pop & ~empty;
  // empty read repeats the last byte taken
  assign rdata   = empty ? last_reg : mem[rd_ptr];

  // storage, write to a full queue is dropped
  always @(posedge pclk)
  begin
    if (push_ok)
      mem[wr_ptr] <= wdata;
  end

  // pointers and fill count
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr   <= 4'h0;
      rd_ptr   <= 4'h0;
      count    <= 5'h00;
      last_reg <= 9'h000;
    end
    else if (clear)
    begin
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
      count  <= 5'h00;
    end
    else
    begin
      if (push_ok)
        wr_ptr <= wr_ptr + 4'h1;
      if (pop_ok)
      begin
        rd_ptr   <= rd_ptr + 4'h1;
        last_reg <= mem[rd_ptr];
      end
      if (push_ok & ~pop_ok)
        count <= count + 5'h01;
      else if (pop_ok & ~push_ok)
        count <= count - 5'h01;
    end
  end

endmodule // ecp_byte_fifo

// ### hw/cfg_readback_enc.v
`timescale 1ns/1ps

module cfg_readback_enc (
  input  wire [3:0] irq_sel,
  input  wire [1:0] dma_sel,
  output reg  [2:0] irq_code,
  output reg  [2:0] dma_code
);

  // interrupt line to readback code
  always @*
  begin
    case (irq_sel)
      4'hf:    irq_code = 3'h6;
      4'he:    irq_code = 3'h5;
      4'hb:    irq_code = 3'h4;
      4'ha:    irq_code = 3'h3;
      4'h9:    irq_code = 3'h2;
      4'h7:    irq_code = 3'h1;
      4'h5:    irq_code = 3'h7;
      default: irq_code = 3'h0;
    endcase
  end

  // dma channel to readback code
  always @*
  begin
    case (dma_sel)
      2'h3:    dma_code = 3'h3;
      2'h2:    dma_code = 3'h2;
      2'h1:    dma_code = 3'h1;
      default: dma_code = 3'h0;
    endcase
  end

endmodule // cfg_readback_enc

// ### hw/ecp_extended_control.v
// Operation
// - extended control bits 7:5 hold a read/write mode selecting port operation
// - fault disable at 1 blocks fault falling-edge interrupt, ECP mode only
// - fault disable at 0 pulses interrupt on each fault falling edge
// - clearing fault disable while fault asserted raises an interrupt
// - dma enable permits DMA once service mask is 0; clear stops it
// - service mask at 1 blocks DMA and service interrupts; writing 1 never interrupts
// - any service interrupt sets service mask; software clears it to rearm
// - with DMA enabled, terminal count sets service mask
// - no DMA, forward: mask set when free space reaches transmit threshold
// - no DMA, reverse: mask set when fill reaches receive threshold
// - read-only full flag shows queue cannot take a byte
// - read-only empty flag in bit zero shows queue holds nothing
// - mode 000 holds queue reset, open-collector controls, direction ignored
// - mode 001 direction tri-states data, data read returns pins, push-pull
// - mode 010 queues bytes and sends them forward automatically
// - mode 011 shares one queue for data and commands, reverse fills it
// - mode 100 is EPP only with the option enabled, push-pull drivers
// - mode 101 reserved; mode 110 queue usable by host, never sent
// - mode 111 maps the two config readbacks in place of the queue
// - config B bits 5:3 read the encoded selected interrupt line
// - config B bits 2:0 read the encoded selected DMA channel
// - config B bit 6 reads the interrupt line level
// - direction bit 5: 0 out, 1 in, forced out in 000 and 010
// - clearing service mask while condition holds interrupts at once
`timescale 1ns/1ps
`include "ecp_defines.vh"

module ecp_extended_control (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [12:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        fault_in_n,
  input  wire        irq_line_level,
  input  wire [7:0]  pd_in,
  output wire [7:0]  pd_out,
  output wire        pd_oe,
  output wire        strobe_out_n,
  output wire        strobe_oe,
  output wire        autofeed_out_n,
  output wire        autofeed_oe,
  output wire        init_out_n,
  output wire        init_oe,
  output wire        select_in_out_n,
  output wire        select_in_oe,
  output wire        link_tx_valid,
  output wire [7:0]  link_tx_data,
  output wire        link_tx_command,
  input  wire        link_tx_take,
  input  wire        link_rx_valid,
  input  wire [7:0]  link_rx_data,
  output wire        link_rx_ready,
  output wire        dma_req,
  input  wire        dma_ack,
  input  wire        dma_tc,
  input  wire [7:0]  dma_wdata,
  output wire [7:0]  dma_rdata,
  output wire        irq_pulse,
  output wire        epp_active
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  reg  [2:0]  mode_reg;
  reg         fault_dis_reg;
  reg         dma_en_reg;
  reg         svc_mask_reg;
  reg  [5:0]  dcr_reg;
  reg  [7:0]  data_reg;
  reg  [6:0]  select_reg;
  reg         fault_prev_reg;
  reg  [7:0]  prdata_reg;
  reg         pready_reg;
  reg         pslverr_reg;
  reg         irq_reg;
  reg         tx_valid_reg;
  reg  [7:0]  tx_data_reg;
  reg         tx_cmd_reg;
  reg         rx_ready_reg;
  reg         dma_req_reg;
  reg  [7:0]  dma_rdata_reg;
  reg  [7:0]  pd_out_reg;
  reg         pd_oe_reg;
  reg  [3:0]  ctl_out_reg;
  reg  [3:0]  ctl_oe_reg;
  reg         epp_reg;
  reg  [7:0]  rd_mux;
  reg         mapped;
  reg  [8:0]  push_data;

  wire [10:0] idx;
  wire        setup;
  wire        access;
  wire        wr;
  wire        rd;
  wire        dir_eff;
  wire        cfg_mode;
  wire        ecp_mode;
  wire        fwd_tx;
  wire        ecp_rev;
  wire        queue_host;
  wire        host_push;
  wire        cmd_push;
  wire        host_pop;
  wire        dma_hit;
  wire        dma_push;
  wire        dma_pop;
  wire        rx_push;
  wire        tx_pop;
  wire        push;
  wire        pop;
  wire        push_ok;
  wire        pop_ok;
  wire [4:0]  count_next;
  wire [8:0]  fifo_rdata;
  wire [4:0]  count;
  wire [4:0]  free;
  wire        full;
  wire        empty;
  wire        ext_wr;
  wire        dma_fwd;
  wire        dma_rev;
  wire        svc_cond;
  wire        svc_fire;
  wire        fault_fall;
  wire        fault_drop;
  wire        fault_fire;
  wire [2:0]  irq_code;
  wire [2:0]  dma_code;
  wire [3:0]  ctl_lvl;
  wire [3:0]  ctl_oe_next;
  wire [3:0]  ctl_out_next;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode and mode qualifiers

  assign idx        = paddr[12:2];
  assign setup      = psel & ~penable;
  assign access     = psel & penable & pready_reg;
  assign wr         = access & pwrite & ~pslverr_reg;
  assign rd         = access & ~pwrite & ~pslverr_reg;
  assign ext_wr     = wr & (idx == `IDX_EXT);
  assign cfg_mode   = (mode_reg == `MODE_CFG);
  assign ecp_mode   = (mode_reg == `MODE_ECP);
  // direction forced outward in 000 and 010
  assign dir_eff    = (mode_reg == `MODE_SPP) | (mode_reg == `MODE_PPFIFO) ?
                      1'b0 : dcr_reg[`DCR_DIR];
  assign fwd_tx     = ((mode_reg == `MODE_PPFIFO) | ecp_mode) & ~dir_eff;
  assign ecp_rev    = ecp_mode & dir_eff;
  assign queue_host = fwd_tx | (mode_reg == `MODE_TEST);
  // test mode moves dma bytes in either direction
  assign dma_fwd    = fwd_tx | ((mode_reg == `MODE_TEST) & ~dir_eff);
  assign dma_rev    = ecp_rev | ((mode_reg == `MODE_TEST) & dir_eff);

  ////////////////////////////////////////////////////////////////////////////
  // queue traffic

  // host data bytes, command bytes in forward ecp, test mode both ways
  assign host_push  = wr & (idx == `IDX_FIFO) & queue_host;
  assign cmd_push   = wr & (idx == `IDX_DATA) & ecp_mode & ~dir_eff;
  assign host_pop   = rd & (idx == `IDX_FIFO) & (ecp_rev | (mode_reg == `MODE_TEST));
  assign dma_hit    = dma_ack & dma_req_reg;
  assign dma_push   = dma_hit & dma_fwd;
  assign dma_pop    = dma_hit & dma_rev;
  assign rx_push    = link_rx_valid & rx_ready_reg & ecp_rev;
  // test mode never feeds the link
  assign tx_pop     = fwd_tx & ~empty & (~tx_valid_reg | link_tx_take);
  assign push       = host_push | cmd_push | dma_push | rx_push;
  assign pop        = tx_pop | host_pop | dma_pop;
  assign push_ok    = push & ~full;
  assign pop_ok     = pop & ~empty;
  assign count_next = count + {4'h0, push_ok} - {4'h0, pop_ok};
  assign free       = `FIFO_DEPTH - count;

  // source of the byte entering the queue, dma first
  always @*
  begin
    if (dma_push)
      push_data = {1'b0, dma_wdata};
    else if (rx_push)
      push_data = {1'b0, link_rx_data};
    else if (cmd_push)
      push_data = {1'b1, pwdata[7:0]};
    else
      push_data = {1'b0, pwdata[7:0]};
  end

  // queue, held clear in mode 000
  ecp_byte_fifo u_fifo (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (mode_reg == `MODE_SPP),
    .push    (push),
    .wdata   (push_data),
    .pop     (pop),
    .rdata   (fifo_rdata),
    .count   (count),
    .full    (full),
    .empty   (empty)
  );

  // readback encoders for config b
  cfg_readback_enc u_enc (
    .irq_sel  (select_reg[3:0]),
    .dma_sel  (select_reg[5:4]),
    .irq_code (irq_code),
    .dma_code (dma_code)
  );

  ////////////////////////////////////////////////////////////////////////////
  // interrupt conditions

  // service condition per dma and direction
  assign svc_cond   = (mode_reg != `MODE_SPP) &
                      (dma_en_reg ? (dma_hit & dma_tc) :
                       dir_eff ? (count >= `RX_FILL_THR) :
                       (free >= `TX_FREE_THR));
  // a held condition fires as soon as the mask drops
  assign svc_fire   = ~svc_mask_reg & svc_cond;
  assign fault_fall = fault_prev_reg & ~fault_in_n;
  // enabling while fault is already low must not lose the event
  assign fault_drop = ext_wr & fault_dis_reg & ~pwdata[`EXT_FAULT_DIS] & ~fault_in_n;
  assign fault_fire = ecp_mode & ((~fault_dis_reg & fault_fall) | fault_drop);

  ////////////////////////////////////////////////////////////////////////////
  // read data and address map

  always @*
  begin
    rd_mux = 8'h00;
    mapped = 1'b1;
    case (idx)
      `IDX_DATA:
        rd_mux = (mode_reg == `MODE_SPP) ? data_reg : pd_in;
      `IDX_DCR:
        rd_mux = {2'h0, dcr_reg};
      `IDX_FIFO:
        rd_mux = cfg_mode ? `CFG_A_VALUE : fifo_rdata[7:0];
      `IDX_CFG_B:
      begin
        mapped = cfg_mode;
        rd_mux = {1'b0, irq_line_level, irq_code, dma_code};
      end
      `IDX_EXT:
        rd_mux = {mode_reg, fault_dis_reg, dma_en_reg, svc_mask_reg,
                  full, empty};
      `IDX_SELECT:
        rd_mux = {1'b0, select_reg};
      default:
        mapped = 1'b0;
    endcase
  end

  // apb answer: data taken at setup, ready during access
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg  <= 8'h00;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else if (setup)
    begin
      prdata_reg  <= rd_mux;
      pready_reg  <= 1'b1;
      pslverr_reg <= ~mapped | (paddr[1:0] != 2'h0);
    end
    else
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  assign prdata  = {24'h00_0000, prdata_reg};
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // software registers

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_reg       <= `MODE_SPP;
      fault_dis_reg  <= 1'b1;
      dma_en_reg     <= 1'b0;
      svc_mask_reg   <= 1'b1;
      dcr_reg        <= `DCR_RESET;
      data_reg       <= 8'h00;
      select_reg     <= `SELECT_RESET;
      fault_prev_reg <= 1'b1;
    end
    else
    begin
      fault_prev_reg <= fault_in_n;
      if (ext_wr)
      begin
        mode_reg      <= pwdata[`EXT_MODE_HI:`EXT_MODE_LO];
        fault_dis_reg <= pwdata[`EXT_FAULT_DIS];
        dma_en_reg    <= pwdata[`EXT_DMA_EN];
      end
      // hardware set wins over a software clear
      if (svc_fire)
        svc_mask_reg <= 1'b1;
      else if (ext_wr)
        svc_mask_reg <= pwdata[`EXT_SVC_MASK];
      if (wr & (idx == `IDX_DCR))
        dcr_reg <= pwdata[5:0];
      if (wr & (idx == `IDX_DATA) & ~ecp_mode)
        data_reg <= pwdata[7:0];
      if (wr & (idx == `IDX_SELECT))
        select_reg <= pwdata[6:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link, dma and interrupt outputs

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_valid_reg  <= 1'b0;
      tx_data_reg   <= 8'h00;
      tx_cmd_reg    <= 1'b0;
      rx_ready_reg  <= 1'b0;
      dma_req_reg   <= 1'b0;
      dma_rdata_reg <= 8'h00;
      irq_reg       <= 1'b0;
      epp_reg       <= 1'b0;
    end
    else
    begin
      if (tx_pop)
      begin
        tx_valid_reg <= 1'b1;
        tx_data_reg  <= fifo_rdata[7:0];
        tx_cmd_reg   <= fifo_rdata[8];
      end
      else if (link_tx_take | ~fwd_tx)
        tx_valid_reg <= 1'b0;
      rx_ready_reg <= ecp_rev & (count_next < `FIFO_DEPTH);
      // dma stops at once when disabled or masked
      dma_req_reg  <= dma_en_reg & ~svc_mask_reg & ~dma_hit &
                      ((dma_fwd & (count_next < `FIFO_DEPTH)) |
                       (dma_rev & (count_next != 5'h00)));
      if (dma_pop)
        dma_rdata_reg <= fifo_rdata[7:0];
      irq_reg <= svc_fire | fault_fire;
      epp_reg <= (mode_reg == `MODE_EPP) & select_reg[6];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers

  // active-low levels, init passes without inversion
  assign ctl_lvl = dcr_reg[3:0] ^ `CTL_INVERT;

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1)
    begin : g_ctl
      // open collector only pulls low in mode 000
      assign ctl_oe_next[i]  = (mode_reg == `MODE_SPP) ? ~ctl_lvl[i] : 1'b1;
      assign ctl_out_next[i] = (mode_reg == `MODE_SPP) ? 1'b0 : ctl_lvl[i];
    end
  endgenerate

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_out_reg <= 4'h0;
      ctl_oe_reg  <= 4'h0;
      pd_out_reg  <= 8'h00;
      pd_oe_reg   <= 1'b0;
    end
    else
    begin
      ctl_out_reg <= ctl_out_next;
      ctl_oe_reg  <= ctl_oe_next;
      pd_out_reg  <= fwd_tx ? tx_data_reg : data_reg;
      pd_oe_reg   <= ~dir_eff;
    end
  end

  assign strobe_out_n    = ctl_out_reg[0];
  assign strobe_oe       = ctl_oe_reg[0];
  assign autofeed_out_n  = ctl_out_reg[1];
  assign autofeed_oe     = ctl_oe_reg[1];
  assign init_out_n      = ctl_out_reg[2];
  assign init_oe         = ctl_oe_reg[2];
  assign select_in_out_n = ctl_out_reg[3];
  assign select_in_oe    = ctl_oe_reg[3];
  assign pd_out          = pd_out_reg;
  assign pd_oe           = pd_oe_reg;
  assign link_tx_valid   = tx_valid_reg;
  assign link_tx_data    = tx_data_reg;
  assign link_tx_command = tx_cmd_reg;
  assign link_rx_ready   = rx_ready_reg;
  assign dma_req         = dma_req_reg;
  assign dma_rdata       = dma_rdata_reg;
  assign irq_pulse       = irq_reg;
  assign epp_active      = epp_reg;

endmodule // ecp_extended_control

// ### verif/ecp_extended_control_chk.sv
`timescale 1ns/1ps
module ecp_extended_control_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [12:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq_line_level,
  input wire logic        link_tx_valid,
  input wire logic [7:0]  link_tx_data,
  input wire logic        link_tx_command,
  input wire logic        link_tx_take,
  input wire logic        dma_req,
  input wire logic        dma_ack,
  input wire logic        dma_tc,
  input wire logic        irq_pulse
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  //////////////////////////////
  // register bus timing
  a_pready_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_pready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_unaligned: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("unaligned access not refused");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_prdata_upper: assert property (pready |-> prdata[31:8] == 24'h00_0000)
    else $error("prdata upper bits set");
  a_cfg_level: assert property (psel && !penable && !pwrite && paddr == 13'h1004 |=>
    pslverr || prdata[6] == $past(irq_line_level))
    else $error("irq level readback wrong");
  //////////////////////////////
  // dma, service and link
  a_dma_drop: assert property (dma_req && dma_ack |=> !dma_req)
    else $error("dma_req held after ack");
  a_tc_irq: assert property (dma_req && dma_ack && dma_tc |=> irq_pulse ##1 !dma_req)
    else $error("terminal count without interrupt");
  a_tx_hold: assert property (link_tx_valid && !link_tx_take |=>
    link_tx_valid && $stable(link_tx_data) && $stable(link_tx_command))
    else $error("offered byte changed before take");
endmodule // ecp_extended_control_chk

bind ecp_extended_control ecp_extended_control_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq_line_level(irq_line_level), .link_tx_valid(link_tx_valid),
  .link_tx_data(link_tx_data), .link_tx_command(link_tx_command),
  .link_tx_take(link_tx_take), .dma_req(dma_req), .dma_ack(dma_ack),
  .dma_tc(dma_tc), .irq_pulse(irq_pulse)
);

// ### verif/pp_peripheral.sv
`timescale 1ns/1ps
module pp_peripheral (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       link_tx_valid,
  input  wire logic [7:0] link_tx_data,
  input  wire logic       link_tx_command,
  input  wire logic       link_rx_ready,
  input  wire logic       fault_drive_n,
  input  wire logic       rx_on,
  output logic            link_tx_take,
  output wire logic       link_rx_valid,
  output wire logic [7:0] link_rx_data,
  output wire logic       fault_in_n,
  output logic            got,
  output logic [8:0]      got_byte
);
  logic [2:0] cnt;
  logic [2:0] rx_n;
  // fault level follows the bench
  assign fault_in_n = fault_drive_n;
  // four reverse bytes, scrambled data when idle
  assign link_rx_valid = rx_on && rx_n < 3'h4;
  assign link_rx_data = link_rx_valid ? 8'ha0 + {5'h00, rx_n} : {cnt, cnt, 2'h1} ^ 8'h5a;
  // take forward bytes at an uneven pace
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cnt <= 3'h0;
      rx_n <= 3'h0;
      link_tx_take <= 1'h0;
      got <= 1'h0;
      got_byte <= 9'h000;
    end
    else
    begin
      cnt <= cnt + 3'h1;
      link_tx_take <= cnt == 3'h0 || cnt == 3'h1 || cnt == 3'h5;
      got <= link_tx_valid && link_tx_take;
      got_byte <= {link_tx_command, link_tx_data};
      if (link_rx_valid && link_rx_ready)
        rx_n <= rx_n + 3'h1;
    end
endmodule // pp_peripheral

// ### verif/ecp_extended_control_tb.sv
`timescale 1ns/1ps
module ecp_extended_control_tb;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [12:0] paddr;
  logic [31:0] pwdata, seed;
  wire  [31:0] prdata;
  wire  [7:0]  link_tx_data, link_rx_data;
  wire  [8:0]  got_byte;
  wire         pready, pslverr, pd_oe, link_tx_valid, link_tx_command, link_tx_take;
  wire         link_rx_valid, link_rx_ready, dma_req, irq_pulse, epp_active, fault_in_n, got, init_oe;
  logic        irq_line_level, dma_ack, dma_tc, fault_drive_n, rx_on;
  logic [7:0]  pd_in, dma_wdata;
  logic [7:0]  b [16];
  logic [9:0]  rdq [$];
  logic [8:0]  txq [$];
  logic [9:0]  e;
  int          fails, total_checks, irqs, cyc;

  ecp_extended_control dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fault_in_n(fault_in_n), .irq_line_level(irq_line_level),
    .pd_in(pd_in), .pd_out(), .pd_oe(pd_oe), .strobe_out_n(), .strobe_oe(),
    .autofeed_out_n(), .autofeed_oe(), .init_out_n(), .init_oe(init_oe), .select_in_out_n(),
    .select_in_oe(), .link_tx_valid(link_tx_valid), .link_tx_data(link_tx_data),
    .link_tx_command(link_tx_command), .link_tx_take(link_tx_take),
    .link_rx_valid(link_rx_valid), .link_rx_data(link_rx_data), .link_rx_ready(link_rx_ready),
    .dma_req(dma_req), .dma_ack(dma_ack), .dma_tc(dma_tc), .dma_wdata(dma_wdata),
    .dma_rdata(), .irq_pulse(irq_pulse), .epp_active(epp_active));

  pp_peripheral u_per (.pclk(pclk), .presetn(presetn), .link_tx_valid(link_tx_valid),
    .link_tx_data(link_tx_data), .link_tx_command(link_tx_command),
    .link_rx_ready(link_rx_ready), .fault_drive_n(fault_drive_n), .rx_on(rx_on),
    .link_tx_take(link_tx_take), .link_rx_valid(link_rx_valid), .link_rx_data(link_rx_data),
    .fault_in_n(fault_in_n), .got(got), .got_byte(got_byte));
  //////////////////////////////
  // clock
  initial
  begin
    pclk = 1'h0;
    forever #20 pclk = ~pclk;
  end

  // xorshift source
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  // interrupt line selection code
  function automatic logic [2:0] irq_enc(input logic [3:0] i);
    case (i)
      4'hf: return 3'h6;
      4'he: return 3'h5;
      4'hb: return 3'h4;
      4'ha: return 3'h3;
      4'h9: return 3'h2;
      4'h7: return 3'h1;
      4'h5: return 3'h7;
      default: return 3'h0;
    endcase
  endfunction

  task cmp(input string nm, input logic [31:0] ex, input logic [31:0] got_v);
    total_checks++;
    if (got_v !== ex)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, ex, got_v);
    end
  endtask

  task print_verdict();
    if (fails == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // one apb transfer, held until pready
  task apb(input logic w, input logic [12:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task wr(input logic [12:0] a, input logic [7:0] d);
    apb(1'h1, a, d);
  endtask

  task rd(input logic [12:0] a, input logic [7:0] d, input logic err = 0);
    rdq.push_back({err, err, d});
    apb(1'h0, a, 8'h00);
  endtask

  task settle(input int want);
    repeat (3) @(posedge pclk);
    cmp("irq count", want, irqs);
  endtask
  //////////////////////////////
  // result watchers and timeout
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      print_verdict();
    end
    if (irq_pulse === 1'h1)
      irqs++;
    if (got === 1'h1)
      cmp("link byte", 32'(txq.pop_front()), 32'(got_byte));
    if (psel && penable && pready === 1'h1 && !pwrite)
    begin
      e = rdq.pop_front();
      cmp("pslverr", 32'(e[8]), 32'(pslverr));
      if (!e[9])
        cmp("prdata", {24'h00_0000, e[7:0]}, prdata);
    end
  end
  //////////////////////////////
  // main sequence
  initial
  begin
    {psel, penable, pwrite, dma_ack, dma_tc, rx_on, irq_line_level, presetn} = 8'h00;
    fault_drive_n = 1'h1;
    paddr = 13'h0000;
    pwdata = 32'h0000_0000;
    pd_in = 8'h00;
    dma_wdata = 8'h00;
    seed = 32'h5211_6fe9;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    rd(13'h1008, 8'h15);
    wr(13'h100c, 8'h40);
    for (int m = 0; m < 8; m++)
    begin
      wr(13'h1008, {m[2:0], 5'h14});
      rd(13'h1008, {m[2:0], 5'h15});
      if (m == 4)
        cmp("epp_active", 1, 32'(epp_active));
      wr(13'h1008, 8'h14);
    end
    wr(13'h1008, 8'hf4);
    for (int i = 0; i < 16; i++)
    begin
      irq_line_level <= i[0];
      wr(13'h100c, {2'h0, i[1:0], i[3:0]});
      rd(13'h1004, {1'h0, i[0], irq_enc(i[3:0]), 1'h0, i[1:0]});
    end
    rd(13'h1000, 8'h10);
    rd(13'h1009, 8'h00, 1);
    wr(13'h1008, 8'h14);
    rd(13'h1004, 8'h00, 1);
    wr(13'h1008, 8'hd4);
    wr(13'h0008, 8'h20);
    wr(13'h1008, 8'hd0);
    for (int i = 0; i < 16; i++)
    begin
      b[i] = rnd();
      wr(13'h1000, b[i]);
    end
    settle(1);
    rd(13'h1008, 8'hd6);
    wr(13'h1008, 8'hd0);
    settle(2);
    wr(13'h1008, 8'hd4);
    wr(13'h0008, 8'h00);
    for (int i = 0; i < 16; i++)
      rd(13'h1000, b[i]);
    rd(13'h1000, b[15]);
    rd(13'h1008, 8'hd5);
    settle(2);
    wr(13'h1008, 8'hd0);
    settle(3);
    wr(13'h1008, 8'hd8);
    for (int i = 0; i < 3; i++)
    begin
      while (dma_req !== 1'h1) @(posedge pclk);
      b[i] = rnd();
      dma_ack <= 1'h1;
      dma_wdata <= b[i];
      dma_tc <= i == 2;
      @(posedge pclk);
      dma_ack <= 1'h0;
      dma_tc <= 1'h0;
      @(posedge pclk);
    end
    settle(4);
    cmp("dma_req", 0, 32'(dma_req));
    wr(13'h1008, 8'hd4);
    for (int i = 0; i < 3; i++)
      rd(13'h1000, b[i]);
    wr(13'h1008, 8'h14);
    wr(13'h1008, 8'h74);
    fault_drive_n <= 1'h0;
    settle(4);
    wr(13'h1008, 8'h64);
    settle(5);
    fault_drive_n <= 1'h1;
    repeat (2) @(posedge pclk);
    fault_drive_n <= 1'h0;
    settle(6);
    for (int j = 0; j < 2; j++)
    begin
      wr(13'h1008, 8'h14);
      wr(13'h1008, j == 0 ? 8'h74 : 8'h54);
      for (int i = 0; i < 5; i++)
      begin
        b[0] = rnd();
        txq.push_back({j == 0 && b[0][0], b[0]});
        wr(j == 0 && b[0][0] ? 13'h0000 : 13'h1000, b[0]);
      end
      while (txq.size() > 0) @(posedge pclk);
    end
    pd_in <= rnd();
    wr(13'h1008, 8'h14);
    wr(13'h1008, 8'h34);
    wr(13'h0008, 8'h20);
    wr(13'h1008, 8'h74);
    rx_on <= 1'h1;
    @(posedge pclk);
    while (link_rx_valid !== 1'h0) @(posedge pclk);
    rx_on <= 1'h0;
    for (int i = 0; i < 4; i++)
      rd(13'h1000, 8'ha0 + 8'(i));
    wr(13'h1008, 8'h14);
    wr(13'h1008, 8'h34);
    rd(13'h0000, pd_in);
    cmp("pd_oe", 0, 32'(pd_oe));
    wr(13'h1008, 8'h14);
    repeat (2) @(posedge pclk);
    cmp("pd_oe", 1, 32'(pd_oe));
    cmp("init_oe", 1, 32'(init_oe));
    print_verdict();
  end
endmodule // ecp_extended_control_tb
